/* File: rtl/bfs_regs.svh */
/*
  Timing counts and thresholds of the converter fault supervisor.
  Assumes a 20 MHz supervisor clock; included by bare name.
*/
`ifndef BFS_REGS_SVH
`define BFS_REGS_SVH

`define BFS_CLK_MHZ 20
`define BFS_TURNON_SHIFT_NS 110
`define BFS_TURNON_SHIFT_CYC ((`BFS_TURNON_SHIFT_NS * `BFS_CLK_MHZ + 999) / 1000)
`define BFS_FOLDBACK_US 28
`define BFS_FOLDBACK_CYC (`BFS_FOLDBACK_US * `BFS_CLK_MHZ)
`define BFS_LOCAL_RESTART_MS 14
`define BFS_LOCAL_RESTART_CYC (`BFS_LOCAL_RESTART_MS * 1000 * `BFS_CLK_MHZ)
`define BFS_SYS_RESTART_MS 100
`define BFS_SYS_RESTART_CYC (`BFS_SYS_RESTART_MS * 1000 * `BFS_CLK_MHZ)
`define BFS_CONSEC_CYCLES 16
`define BFS_CONSEC_W 5
`define BFS_FOLD_W 10
`define BFS_SHIFT_W 2
`define BFS_TIMER_W 21

`endif

/* File: rtl/bfs_pkg.sv */
/*
  Types of the converter fault supervisor.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package bfs_pkg;

  // Comparator levels of one converter
  typedef struct packed {
    logic pg_below;
    logic cur_warn;
    logic cur_lim;
    logic cur_short;
  } bfs_cmp_t;

  // Configuration of one converter
  typedef struct packed {
    logic enable;
    logic fault_unmask_bit;
    logic current_fault_mask;
    logic phase_delay_en;
    logic phase_falling;
  } bfs_cfg_t;

  typedef enum logic [0:0] {
    BFS_RUN,
    BFS_SUPPLY_FAULT
  } bfs_state_t;

endpackage

`default_nettype wire

/* File: rtl/bfs_sync.sv */
/*
  Two-flop synchroniser for a group of levels.
  Assumes inputs arrive from outside the clk domain.
*/
`timescale 1ns/10ps
`default_nettype none

module bfs_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

`default_nettype wire

/* File: rtl/bfs_supervisor.sv */
/*
  Fault supervisor for the step-down converters: power-good tracking,
  peak-current cycle counting, short-circuit shutdown and restart,
  foldback, phase alignment of high-side turn-on, interrupt line.
  Assumes comparator and master clock pins are asynchronous, while
  configuration and host read strobes come from logic on clk.
*/
`timescale 1ns/10ps
`default_nettype none

`include "bfs_regs.svh"

// Behaviour
// - Power-good flag is 0 while the output is under its threshold.
// - Unmasked power-good loss drives the interrupt line low.
// - Power-good interrupt holds until off or in regulation, and read.
// - Turn-on shift delays high-side turn-on by 110 ns rounded up to 3 clk cycles, 150 ns at 20 MHz.
// - Turn-on follows rising or falling master edge as selected.
// - Reaching the limit ends switch conduction for the rest of the cycle.
// - 16 consecutive cycles at 75 percent set warning and interrupt.
// - 16 consecutive cycles at full limit assert the interrupt.
// - Short-circuit level shuts the supply at once; unmasked asserts interrupt.
// - After short-circuit shutdown, the supply restarts after 14 ms.
// - Unmasked short enters supply fault, all off, restart after 100 ms.
// - After soft-start, out of regulation over 28 us enables foldback.
// - Regaining regulation in foldback restores the default limit.
// - Overcurrent and short events latch in the current-limit status.
// - Current fault mask suppresses the overcurrent and short interrupt and supply fault entry; local shutdown and status still occur.
module bfs_supervisor #(
  parameter int N = 3,
  parameter int LOCAL_RESTART_CYC = `BFS_LOCAL_RESTART_CYC,
  parameter int SYS_RESTART_CYC = `BFS_SYS_RESTART_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic master_sw_clk,
  input wire logic [N-1:0] soft_start_done,
  input wire bfs_pkg::bfs_cmp_t [N-1:0] cmp,
  input wire bfs_pkg::bfs_cfg_t [N-1:0] cfg,
  input wire logic [N-1:0] rd_power_good,
  input wire logic [N-1:0] rd_current_warning,
  input wire logic [N-1:0] rd_current_limit,
  output wire logic [N-1:0] power_good_flag,
  output wire logic [N-1:0] current_warning_flag,
  output wire logic [N-1:0] current_limit_status,
  output wire logic [N-1:0] foldback_active,
  output wire logic [N-1:0] hs_gate_on,
  output wire logic [N-1:0] conv_shutdown,
  output logic supply_fault_state,
  output logic system_restart,
  output logic interrupt_request_low
);

  localparam int SW = 1 + N + N * $bits(bfs_pkg::bfs_cmp_t);
  localparam logic [`BFS_CONSEC_W-1:0] CONSEC = `BFS_CONSEC_W'(`BFS_CONSEC_CYCLES);
  localparam logic [`BFS_FOLD_W-1:0] FOLD_CYC = `BFS_FOLD_W'(`BFS_FOLDBACK_CYC);
  localparam logic [`BFS_SHIFT_W-1:0] SHIFT_CYC = `BFS_SHIFT_W'(`BFS_TURNON_SHIFT_CYC);
  localparam logic [`BFS_TIMER_W-1:0] LOC_CYC = `BFS_TIMER_W'(LOCAL_RESTART_CYC);
  localparam logic [`BFS_TIMER_W-1:0] SYS_CYC = `BFS_TIMER_W'(SYS_RESTART_CYC);

  logic [SW-1:0] sync_q;
  logic msw;
  logic msw_prev;
  logic [N-1:0] ss_done;
  bfs_pkg::bfs_cmp_t [N-1:0] cs;
  bfs_pkg::bfs_state_t state;
  logic [`BFS_TIMER_W-1:0] sys_cnt;
  logic [N-1:0] sys_req;
  logic [N-1:0] irq_src;
  wire m_rise;
  wire m_fall;
  wire in_fault;
  wire sys_done;

  // Counter step with saturation, used by both current levels
  function automatic logic [`BFS_CONSEC_W-1:0] consec_step(
    input logic hit,
    input logic [`BFS_CONSEC_W-1:0] cnt
  );
    if (!hit)
      consec_step = '0;
    else if (cnt == CONSEC)
      consec_step = cnt;
    else
      consec_step = cnt + `BFS_CONSEC_W'(1);
  endfunction

  bfs_sync #(.W(SW)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({master_sw_clk, soft_start_done, cmp}),
    .q(sync_q)
  );

  assign msw = sync_q[SW-1];
  assign ss_done = sync_q[SW-2 -: N];
  assign cs = sync_q[N*$bits(bfs_pkg::bfs_cmp_t)-1:0];
  assign m_rise = msw & ~msw_prev;
  assign m_fall = ~msw & msw_prev;
  assign in_fault = (state == bfs_pkg::BFS_SUPPLY_FAULT);
  assign sys_done = in_fault && (sys_cnt == `BFS_TIMER_W'(1));

  // Supply fault state and system restart timer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      msw_prev <= 1'b0;
      state <= bfs_pkg::BFS_RUN;
      sys_cnt <= '0;
      supply_fault_state <= 1'b0;
      system_restart <= 1'b0;
      interrupt_request_low <= 1'b1;
    end
    else
    begin
      msw_prev <= msw;
      system_restart <= sys_done;
      interrupt_request_low <= ~(|irq_src);
      case (state)
        bfs_pkg::BFS_RUN:
        begin
          if (|sys_req)
          begin
            state <= bfs_pkg::BFS_SUPPLY_FAULT;
            sys_cnt <= SYS_CYC;
            supply_fault_state <= 1'b1;
          end
        end
        bfs_pkg::BFS_SUPPLY_FAULT:
        begin
          if (sys_done)
          begin
            state <= bfs_pkg::BFS_RUN;
            supply_fault_state <= 1'b0;
          end
          else
            sys_cnt <= sys_cnt - `BFS_TIMER_W'(1);
        end
        default:
        begin
          state <= bfs_pkg::BFS_RUN;
          supply_fault_state <= 1'b0;
        end
      endcase
    end
  end

  for (genvar i = 0; i < N; i++)
  begin : g_ch
    logic pg;
    logic warn_hit;
    logic lim_hit;
    logic [`BFS_CONSEC_W-1:0] warn_cnt;
    logic [`BFS_CONSEC_W-1:0] lim_cnt;
    logic warn_flag;
    logic lim_stat;
    logic pg_irq;
    logic pg_seen;
    logic shut;
    logic [`BFS_TIMER_W-1:0] rs_cnt;
    logic [`BFS_FOLD_W-1:0] oor_cnt;
    logic fold;
    logic gate;
    logic [`BFS_SHIFT_W-1:0] dly;
    wire on;
    wire below;
    wire warn_cond;
    wire lim_cond;
    wire short_evt;
    wire pg_cond;
    wire next_pg_irq;
    wire next_pg_seen;
    wire next_warn_flag;
    wire next_lim_stat;
    wire turn_edge;
    wire cut;
    wire oor;

    assign on = cfg[i].enable & ~shut & ~in_fault;
    assign below = cs[i].pg_below;
    assign warn_cond = (warn_cnt == CONSEC);
    assign lim_cond = (lim_cnt == CONSEC);
    assign short_evt = on & cs[i].cur_short;
    assign pg_cond = cfg[i].fault_unmask_bit & cfg[i].enable & below;
    // Holds until condition gone and a read seen; a new loss wins
    assign next_pg_irq = pg_cond | (pg_irq & ~(pg_seen | rd_power_good[i]));
    assign next_pg_seen = next_pg_irq & (pg_seen | rd_power_good[i]);
    assign next_warn_flag = warn_cond | (warn_flag & ~rd_current_warning[i]);
    assign next_lim_stat = lim_cond | short_evt | cs[i].cur_short
      | (lim_stat & ~rd_current_limit[i]);
    assign turn_edge = cfg[i].phase_falling ? m_fall : m_rise;
    assign cut = cs[i].cur_lim | cs[i].cur_short | ~on;
    assign oor = ss_done[i] & on & below;
    assign sys_req[i] = short_evt & ~cfg[i].current_fault_mask;
    assign irq_src[i] = pg_irq | warn_flag
      | ((lim_stat | lim_cond) & ~cfg[i].current_fault_mask);

    assign power_good_flag[i] = pg;
    assign current_warning_flag[i] = warn_flag;
    assign current_limit_status[i] = lim_stat;
    assign foldback_active[i] = fold;
    assign hs_gate_on[i] = gate;
    assign conv_shutdown[i] = shut;

    // Status, interrupt and consecutive-cycle counters
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        pg <= 1'b0;
        warn_hit <= 1'b0;
        lim_hit <= 1'b0;
        warn_cnt <= '0;
        lim_cnt <= '0;
        warn_flag <= 1'b0;
        lim_stat <= 1'b0;
        pg_irq <= 1'b0;
        pg_seen <= 1'b0;
      end
      else
      begin
        pg <= cfg[i].enable & ~below;
        pg_irq <= next_pg_irq;
        pg_seen <= next_pg_seen;
        warn_flag <= next_warn_flag;
        lim_stat <= next_lim_stat;
        if (m_rise)
        begin
          warn_cnt <= consec_step(on & (warn_hit | cs[i].cur_warn), warn_cnt);
          lim_cnt <= consec_step(on & (lim_hit | cs[i].cur_lim), lim_cnt);
          warn_hit <= 1'b0;
          lim_hit <= 1'b0;
        end
        else
        begin
          warn_hit <= warn_hit | cs[i].cur_warn;
          lim_hit <= lim_hit | cs[i].cur_lim;
        end
      end
    end

    // Short-circuit shutdown and local restart timer
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        shut <= 1'b0;
        rs_cnt <= '0;
      end
      else if (short_evt)
      begin
        shut <= 1'b1;
        rs_cnt <= LOC_CYC;
      end
      else if (shut && (rs_cnt == `BFS_TIMER_W'(1)))
        shut <= 1'b0;
      else if (shut)
        rs_cnt <= rs_cnt - `BFS_TIMER_W'(1);
    end

    // Foldback after soft-start
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        oor_cnt <= '0;
        fold <= 1'b0;
      end
      else if (!oor)
      begin
        oor_cnt <= '0;
        fold <= 1'b0;
      end
      else if (oor_cnt == FOLD_CYC)
        fold <= 1'b1;
      else
        oor_cnt <= oor_cnt + `BFS_FOLD_W'(1);
    end

    // High-side turn-on timing and cycle-by-cycle cut
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        gate <= 1'b0;
        dly <= '0;
      end
      else if (cut)
      begin
        gate <= 1'b0;
        dly <= '0;
      end
      else if (turn_edge && cfg[i].phase_delay_en)
        dly <= SHIFT_CYC;
      else if (turn_edge)
        gate <= 1'b1;
      else if (dly == `BFS_SHIFT_W'(1))
      begin
        gate <= 1'b1;
        dly <= '0;
      end
      else if (dly != '0)
        dly <= dly - `BFS_SHIFT_W'(1);
    end
  end

endmodule

`default_nettype wire

/* File: dv/bfs_host_model.sv */
/*
  Host processor model: status read strobes, manual or polled.
  Assumes strobes are taken on the rising edge of clk.
*/
`timescale 1ns/10ps
`default_nettype none
module bfs_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic interrupt_request_low,
  input wire logic auto_en,
  input wire logic [2:0] rd_req,
  output logic [2:0] rd_power_good,
  output logic [2:0] rd_current_warning,
  output logic [2:0] rd_current_limit
);
  logic [1:0] poll;
  wire logic [2:0] next_rd;
  // Slow polling of all status while interrupted
  assign next_rd = rd_req | {3{auto_en && !interrupt_request_low && poll == 2'h3}};
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      poll <= 2'h0;
      rd_power_good <= 3'h0;
      rd_current_warning <= 3'h0;
      rd_current_limit <= 3'h0;
    end
    else
    begin
      poll <= poll + 2'h1;
      rd_power_good <= {3{next_rd[0]}};
      rd_current_warning <= {3{next_rd[1]}};
      rd_current_limit <= {3{next_rd[2]}};
    end
  end
endmodule
`default_nettype wire

/* File: dv/bfs_supervisor_chk.sv */
/*
  Port checks of the fault supervisor.
  Assumes one clk domain and short restart counts.
*/
`timescale 1ns/10ps
`default_nettype none
module bfs_supervisor_chk #(
  parameter int N = 3,
  parameter int LOCAL_RESTART_CYC = 50,
  parameter int SYS_RESTART_CYC = 80
) (
  input wire logic clk,
  input wire logic rst,
  input wire bfs_pkg::bfs_cmp_t [N-1:0] cmp,
  input wire bfs_pkg::bfs_cfg_t [N-1:0] cfg,
  input wire logic [N-1:0] rd_current_warning,
  input wire logic [N-1:0] rd_current_limit,
  input wire logic [N-1:0] power_good_flag,
  input wire logic [N-1:0] current_warning_flag,
  input wire logic [N-1:0] current_limit_status,
  input wire logic [N-1:0] hs_gate_on,
  input wire logic [N-1:0] conv_shutdown,
  input wire logic supply_fault_state,
  input wire logic system_restart,
  input wire logic interrupt_request_low
);
  localparam int LR_LO = LOCAL_RESTART_CYC - 2;
  localparam int LR_HI = LOCAL_RESTART_CYC + 4;
  localparam int SR_LO = SYS_RESTART_CYC - 2;
  localparam int SR_HI = SYS_RESTART_CYC + 4;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_pg_lost;
    (cfg[0].enable && cfg[0].fault_unmask_bit && cmp[0].pg_below)[*5];
  endsequence
  property p_pg_low; cmp[0].pg_below[*4] |-> !power_good_flag[0]; endproperty
  property p_pg_irq; s_pg_lost |-> !interrupt_request_low; endproperty
  property p_lim_gate; cmp[2].cur_lim[*4] |-> !hs_gate_on[2]; endproperty
  property p_short_off; $rose(conv_shutdown[1]) |-> current_limit_status[1] && !hs_gate_on[1];
  endproperty
  property p_local_rst; $rose(conv_shutdown[1]) |-> ##[LR_LO:LR_HI] !conv_shutdown[1];
  endproperty
  property p_sys_rst; $rose(supply_fault_state) |-> ##[SR_LO:SR_HI] system_restart; endproperty
  property p_lim_hold; current_limit_status[2] && !rd_current_limit[2] |=> current_limit_status[2];
  endproperty
  property p_warn_hold;
    current_warning_flag[1] && !rd_current_warning[1] |=> current_warning_flag[1];
  endproperty
  a_pg_low: assert property (p_pg_low) else $error("pg flag high");
  a_pg_irq: assert property (p_pg_irq) else $error("pg irq missing");
  a_lim_gate: assert property (p_lim_gate) else $error("gate on at limit");
  a_short_off: assert property (p_short_off) else $error("short response");
  a_local_rst: assert property (p_local_rst) else $error("local restart time");
  a_sys_rst: assert property (p_sys_rst) else $error("system restart time");
  a_lim_hold: assert property (p_lim_hold) else $error("limit status lost");
  a_warn_hold: assert property (p_warn_hold) else $error("warning lost");
endmodule
bind bfs_supervisor bfs_supervisor_chk #(.N(N), .LOCAL_RESTART_CYC(LOCAL_RESTART_CYC),
  .SYS_RESTART_CYC(SYS_RESTART_CYC)) u_chk (.clk(clk), .rst(rst), .cmp(cmp), .cfg(cfg),
  .rd_current_warning(rd_current_warning), .rd_current_limit(rd_current_limit),
  .power_good_flag(power_good_flag), .current_warning_flag(current_warning_flag),
  .current_limit_status(current_limit_status), .hs_gate_on(hs_gate_on),
  .conv_shutdown(conv_shutdown), .supply_fault_state(supply_fault_state),
  .system_restart(system_restart), .interrupt_request_low(interrupt_request_low));
`default_nettype wire

/* File: dv/bfs_supervisor_tb_top.sv */
/*
  Self-checking bench of the fault supervisor with a host model.
  Assumes short restart counts and a 20 MHz clk.
*/
`timescale 1ns/10ps
`default_nettype none
module bfs_supervisor_tb_top;
  localparam int LR = 50;
  localparam int SR = 80;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic msw = 1'b0;
  logic auto_en = 1'b0;
  logic [2:0] rd_req = 3'h0;
  logic [2:0] ssd = 3'h0;
  bfs_pkg::bfs_cmp_t [2:0] cmp = '0;
  bfs_pkg::bfs_cfg_t [2:0] cfg = '0;
  wire logic [2:0] rpg, rwn, rlm, pg, wn, lm, fb, gate, sd;
  wire logic sfs, srst, irq_n;
  int error_cnt = 0;
  int n_tests = 0;
  int k;
  always #25 clk = ~clk;
  // Slow master clock keeps on-time long
  always #400 msw = ~msw;
  bfs_supervisor #(.N(3), .LOCAL_RESTART_CYC(LR), .SYS_RESTART_CYC(SR)) dut (.clk(clk),
    .rst(rst), .master_sw_clk(msw), .soft_start_done(ssd), .cmp(cmp), .cfg(cfg),
    .rd_power_good(rpg), .rd_current_warning(rwn), .rd_current_limit(rlm),
    .power_good_flag(pg), .current_warning_flag(wn), .current_limit_status(lm),
    .foldback_active(fb), .hs_gate_on(gate), .conv_shutdown(sd), .supply_fault_state(sfs),
    .system_restart(srst), .interrupt_request_low(irq_n));
  bfs_host_model host (.clk(clk), .rst(rst), .interrupt_request_low(irq_n), .auto_en(auto_en),
    .rd_req(rd_req), .rd_power_good(rpg), .rd_current_warning(rwn), .rd_current_limit(rlm));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t bit %b not %b", $time, got, exp);
    end
  endtask
  task automatic chki(input int got, input int exp);
    n_tests++;
    if (got != exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t latency %0d not %0d", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rd(input logic [2:0] m);
    rd_req = m;
    cyc(1);
    rd_req = 3'h0;
    cyc(3);
  endtask
  function automatic int exp_lat(input logic dl);
    return dl ? 6 : 3;
  endfunction
  task automatic gate_lat(input logic fall, input logic dl);
    int n;
    n = 0;
    cfg[2].enable = 1'b0;
    cfg[2].phase_falling = fall;
    cfg[2].phase_delay_en = dl;
    cyc(1);
    if (fall)
      @(posedge msw);
    else
      @(negedge msw);
    cfg[2].enable = 1'b1;
    if (fall)
      @(negedge msw);
    else
      @(posedge msw);
    while (gate[2] !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chki(n, exp_lat(dl));
  endtask
  initial
  begin
    #1000000;
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(32'hff9b));
    cyc(16);
    rst = 1'b0;
    cyc(4);
    chk(irq_n, 1'b1);
    for (k = 0; k < 3; k++) cfg[k].enable = 1'b1;
    cfg[0].fault_unmask_bit = 1'b1;
    cfg[1].current_fault_mask = 1'b1;
    cyc(6);
    chk(pg[0], 1'b1);
    cmp[1].pg_below = 1'b1;
    cyc(6);
    chk(pg[1], 1'b0);
    chk(irq_n, 1'b1);
    cmp[0].pg_below = 1'b1;
    cyc(6);
    chk(pg[0], 1'b0);
    chk(irq_n, 1'b0);
    cmp[0].pg_below = 1'b0;
    cmp[1].pg_below = 1'b0;
    cyc(6);
    chk(irq_n, 1'b0);
    rd(3'h1);
    chk(irq_n, 1'b1);
    k = 8 + $urandom % 6;
    cmp[1].cur_warn = 1'b1;
    cyc(16 * k);
    cmp[1].cur_warn = 1'b0;
    cyc(32);
    cmp[1].cur_warn = 1'b1;
    cyc(16 * k);
    chk(wn[1], 1'b0);
    cyc(160);
    chk(wn[1], 1'b1);
    chk(irq_n, 1'b0);
    rd(3'h2);
    chk(wn[1], 1'b1);
    cmp[1].cur_warn = 1'b0;
    cyc(40);
    rd(3'h2);
    chk(wn[1], 1'b0);
    chk(irq_n, 1'b1);
    cmp[2].cur_lim = 1'b1;
    cyc(288);
    chk(gate[2], 1'b0);
    chk(irq_n, 1'b0);
    cmp[2].cur_lim = 1'b0;
    cyc(40);
    chk(lm[2], 1'b1);
    rd(3'h4);
    chk(lm[2], 1'b0);
    chk(irq_n, 1'b1);
    cmp[1].cur_short = 1'b1;
    cyc(4);
    cmp[1].cur_short = 1'b0;
    chk(sd[1], 1'b1);
    chk(sfs, 1'b0);
    chk(irq_n, 1'b1);
    cyc(LR + 4);
    chk(sd[1], 1'b0);
    rd(3'h4);
    auto_en = 1'b1;
    cmp[0].cur_short = 1'b1;
    cyc(4);
    cmp[0].cur_short = 1'b0;
    chk(sfs, 1'b1);
    chk(irq_n, 1'b0);
    chk(gate === 3'h0, 1'b1);
    k = 0;
    while (srst !== 1'b1 && k < SR + 8)
    begin
      cyc(1);
      k++;
    end
    chki(k, SR - 1);
    chk(sfs, 1'b0);
    cyc(20);
    chk(irq_n, 1'b1);
    auto_en = 1'b0;
    ssd = 3'h7;
    cmp[1].pg_below = 1'b1;
    cyc(550);
    chk(fb[1], 1'b0);
    cyc(25);
    chk(fb[1], 1'b1);
    cmp[1].pg_below = 1'b0;
    cyc(5);
    chk(fb[1], 1'b0);
    for (k = 0; k < 4; k++) gate_lat(k[1], k[0]);
    tally_and_finish();
  end
endmodule
`default_nettype wire
